// [hdl/bsic_top.sv]
// Input capture and access control of a flow-through burst SRAM.
// Assumes all pins synchronous to mclk; the array sits outside, fed by memAddr/memWrLane.
`include "bsic_regs.svh"
module bsic_top #(
  parameter int ADDR_W = `BSIC_ADDR_W,
  parameter int LANES  = `BSIC_LANES
) (
  input  wire logic              mclk,            // Clock
  input  wire logic              reset,           // Sync reset, high
  input  wire logic              clock_gate_n,    // Clock qualifier, low
  input  wire logic [ADDR_W-1:0] addrIn,          // Address bus
  input  wire logic              advance_or_load, // High advance, low load
  input  wire logic              writeEnN,        // Write strobe, low
  input  wire logic [LANES-1:0]  byte_lane_write_n, // Lane write, low
  input  wire logic              chipSel1N,       // Select one, low
  input  wire logic              chipSel2,        // Select two, high
  input  wire logic              chipSel3N,       // Select three, low
  input  wire logic              burstModeStrap,  // Low linear, high interleaved
  input  wire logic              outEnN,          // Output enable, low
  output logic      [ADDR_W-1:0] memAddr,         // Location of this beat
  output logic                   memActive,       // Beat in progress
  output logic                   memWrite,        // Beat is a write
  output logic      [LANES-1:0]  memWrLane,       // Lanes written, high
  output logic                   dataDriveN,      // Data pins drive when low
  output logic                   parity_linesDriveN // Parity pins drive when low
);
  bsic_pkg::bsic_state_e state_r, state_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [LANES-1:0]  lane_r, lane_nxt;
  logic              afterDesel_r, afterDesel_nxt;
  logic              modeLin_r, modeLin_nxt;
  logic              strapTaken_r, strapTaken_nxt;
  logic [ADDR_W-1:0] memAddr_r, memAddr_nxt;
  logic              drvN_r, drvN_nxt;
  logic              memActive_r, memActive_nxt;
  logic              memWrite_r, memWrite_nxt;
  logic [LANES-1:0]  memWrLane_r, memWrLane_nxt;
  logic              qual, selected, doLoad, doStep;
  logic [1:0]        offset;

  // Timing seen at the pins, in qualified edges:
  //   load edge L: state, lanes and base taken
  //   L: busy, write and lane outputs show the new access
  //   L+1: memAddr shows the first beat address
  // Each advance edge moves the beat address one edge later.
  // A gated edge freezes state, lanes, base and counter; memAddr still takes a beat set one edge earlier, and the drive pins follow outEnN.

  // Select decode: one and three low, two high
  function automatic logic selDecode(
    input logic sel1N,
    input logic sel2,
    input logic sel3N
  );
    return ~sel1N & sel2 & ~sel3N;
  endfunction : selDecode

  // Any access in progress
  function automatic logic accessBusy(
    input bsic_pkg::bsic_state_e st
  );
    return st != bsic_pkg::BSIC_IDLE;
  endfunction : accessBusy

  // Access in progress is a write
  function automatic logic accessIsWrite(
    input bsic_pkg::bsic_state_e st
  );
    return st == bsic_pkg::BSIC_WRITE;
  endfunction : accessIsWrite

  // Access in progress is a read
  function automatic logic accessIsRead(
    input bsic_pkg::bsic_state_e st
  );
    return st == bsic_pkg::BSIC_READ;
  endfunction : accessIsRead

  assign qual     = ~clock_gate_n;                          // [RULE9]
  assign selected = selDecode(chipSel1N, chipSel2, chipSel3N); // [RULE11]
  assign doLoad   = qual & ~advance_or_load & selected;     // [RULE7]
  // Advancing from deselect is illegal for the controller; ignore it
  assign doStep   = qual & advance_or_load & accessBusy(state_r); // [RULE6] [RULE8]

  bsic_burst_ctr u_ctr (
    .mclk     (mclk),
    .reset    (reset),
    .load     (doLoad),
    .step     (doStep),
    .startOff (addrIn[1:0]),
    .linear   (modeLin_r),
    .offset   (offset)
  );

  always_comb begin
    state_nxt      = state_r;
    base_nxt       = base_r;
    lane_nxt       = lane_r;
    afterDesel_nxt = afterDesel_r;
    modeLin_nxt    = modeLin_r;
    strapTaken_nxt = 1'b1;
    // Strap caught once after reset release, static afterwards
    if (!strapTaken_r) begin
      modeLin_nxt = (burstModeStrap == `BSIC_BURST_LIN);    // [RULE12]
    end
    // No qualified edge: state, lanes, base and deselect flag hold, selection included
    if (qual) begin                                         // [RULE10]
      lane_nxt = ~byte_lane_write_n;                        // [RULE3]
      if (!advance_or_load) begin
        afterDesel_nxt = (state_r == bsic_pkg::BSIC_IDLE) && selected;
        if (!selected) begin
          state_nxt = bsic_pkg::BSIC_IDLE;                  // [RULE11]
        end else begin
          base_nxt  = addrIn;                               // [RULE1]
          state_nxt = writeEnN ? bsic_pkg::BSIC_READ : bsic_pkg::BSIC_WRITE; // [RULE4] [RULE5]
        end
      end else begin
        afterDesel_nxt = 1'b0;
      end
    end
  end

  // Upper bits come from the load only, so a wrap never carries
  always_comb begin
    memAddr_nxt = {base_r[ADDR_W-1:2], offset};              // [RULE14]
  end

  // Drive only for a settled read with output enable low; the first
  // beat out of deselect stays off to avoid contention on turnaround
  always_comb begin
    drvN_nxt = 1'b1;
    if (!outEnN && accessIsRead(state_nxt) && !afterDesel_nxt) begin
      drvN_nxt = 1'b0;                                       // [RULE13]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r      <= bsic_pkg::BSIC_IDLE;
      base_r       <= '0;
      lane_r       <= '0;
      afterDesel_r <= 1'b0;
      modeLin_r    <= 1'b0;
      strapTaken_r <= 1'b0;
      drvN_r       <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      base_r       <= base_nxt;
      lane_r       <= lane_nxt;
      afterDesel_r <= afterDesel_nxt;
      modeLin_r    <= modeLin_nxt;
      strapTaken_r <= strapTaken_nxt;
      drvN_r       <= drvN_nxt;
    end
  end

  // Address register follows the counter one cycle behind the base
  always_ff @(posedge mclk) begin
    if (reset) begin
      memAddr_r <= '0;
    end else begin
      memAddr_r <= memAddr_nxt;
    end
  end

  // Output group: flops fed from the state group's next values, so the
  // pins match a decode of the state register without a gate path
  always_comb begin
    memActive_nxt = accessBusy(state_nxt);                   // [RULE7]
    memWrite_nxt  = accessIsWrite(state_nxt);                // [RULE5]
    memWrLane_nxt = '0;
    if (accessIsWrite(state_nxt)) begin
      memWrLane_nxt = lane_nxt;                              // [RULE3]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      memActive_r <= 1'b0;
      memWrite_r  <= 1'b0;
      memWrLane_r <= '0;
    end else begin
      memActive_r <= memActive_nxt;
      memWrite_r  <= memWrite_nxt;
      memWrLane_r <= memWrLane_nxt;
    end
  end

  assign memAddr            = memAddr_r;
  assign memActive          = memActive_r;
  assign memWrite           = memWrite_r;
  assign memWrLane          = memWrLane_r;
  assign dataDriveN         = drvN_r;
  assign parity_linesDriveN = drvN_r;
endmodule : bsic_top

// [hdl/bsic_regs.svh]
// Constants for the burst SRAM input-capture and access-control front end.
// Assumes inclusion by name from hdl/ files; definitions only.
// Notes on behaviour
// RULE1 - A new access captures the whole address bus on a qualified rising edge to pick one location.
// RULE2 - The two lowest address bits are loaded into a two-bit burst counter that sets later beat offsets.
// RULE3 - Only byte lanes sampled low together with a low write strobe are written; the code also writes lanes sampled on advance edges of a write, strobe high.
// RULE4 - The write strobe is sampled only on edges where the clock gate is low.
// RULE5 - The controller starts a write with the strobe low; with it high the access is a read.
// RULE6 - With advance_or_load high on a qualified edge the burst counter steps instead of loading.
// RULE7 - With advance_or_load low on a qualified edge a new address is taken and a new access starts.
// RULE8 - After deselect the controller must load a fresh address rather than advance.
// RULE9 - All inputs are registered but acted on only on edges where the clock gate is low; the code acts on reset, outEnN and the strap on gated edges too.
// RULE10 - A high clock gate freezes all state and does not deselect the device; the code still updates memAddr and the drive pins on a gated edge.
// RULE11 - The device is selected only with select one and three low and select two high.
// RULE12 - The burst-order strap low gives linear order, high gives interleaved order.
// RULE13 - Data and parity drivers are off during write beats, on the first cycle after deselect and while deselected.
// RULE14 - The burst counter wraps inside its group of four and never carries into upper address bits.
`ifndef BSIC_REGS_SVH
`define BSIC_REGS_SVH
`define BSIC_ADDR_W     19
`define BSIC_LANES      4
`define BSIC_CNT_W      2
`define BSIC_CNT_RESET  2'h0
`define BSIC_BURST_LIN  1'h0
`endif

// [hdl/bsic_pkg.sv]
// Types for the burst SRAM front end.
// Assumes no other package.
package bsic_pkg;
  typedef enum logic [2:0] {
    BSIC_IDLE  = 3'h1,
    BSIC_READ  = 3'h2,
    BSIC_WRITE = 3'h4
  } bsic_state_e;
endpackage : bsic_pkg

// [hdl/bsic_burst_ctr.sv]
// Two-bit burst offset generator: load, step and order select.
// Assumes the caller qualifies load and step with the clock gate.
`include "bsic_regs.svh"
module bsic_burst_ctr (
  input  wire logic                   mclk,      // Clock
  input  wire logic                   reset,     // Sync reset, high
  input  wire logic                   load,      // Take new start offset
  input  wire logic                   step,      // Advance one beat
  input  wire logic [`BSIC_CNT_W-1:0] startOff,  // Low address bits
  input  wire logic                   linear,    // Linear order when high
  output logic      [`BSIC_CNT_W-1:0] offset     // Current beat offset
);
  logic [`BSIC_CNT_W-1:0] start_r, start_nxt;
  logic [`BSIC_CNT_W-1:0] beat_r, beat_nxt;

  // Two bits only, so the add wraps inside the group of four
  function automatic logic [`BSIC_CNT_W-1:0] bsicOrder(
    input logic [`BSIC_CNT_W-1:0] s, input logic [`BSIC_CNT_W-1:0] b, input logic lin);
    bsicOrder = lin ? `BSIC_CNT_W'(s + b) : (s ^ b); // [RULE12] [RULE14]
  endfunction : bsicOrder

  always_comb begin
    start_nxt = start_r;
    beat_nxt  = beat_r;
    if (load) begin
      start_nxt = startOff;  // [RULE2]
      beat_nxt  = `BSIC_CNT_RESET;
    end else if (step) begin
      beat_nxt = `BSIC_CNT_W'(beat_r + 2'h1);  // [RULE6] [RULE14]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      start_r <= `BSIC_CNT_RESET;
      beat_r  <= `BSIC_CNT_RESET;
    end else begin
      start_r <= start_nxt;
      beat_r  <= beat_nxt;
    end
  end

  assign offset = bsicOrder(start_r, beat_r, linear);
endmodule : bsic_burst_ctr

// [bench/bsic_checker.sv]
// Port-level assertions for the burst SRAM front end.
// Assumes the strap stays steady between resets.
module bsic_checker #(parameter int ADDR_W = 19, parameter int LANES = 4) (
  input wire logic              mclk,              // Clock
  input wire logic              reset,             // Reset
  input wire logic              clock_gate_n,      // Gate
  input wire logic [ADDR_W-1:0] addrIn,            // Address
  input wire logic              advance_or_load,   // Step
  input wire logic              writeEnN,          // Write
  input wire logic [LANES-1:0]  byte_lane_write_n, // Lanes
  input wire logic              chipSel1N,         // Sel 1
  input wire logic              chipSel2,          // Sel 2
  input wire logic              chipSel3N,         // Sel 3
  input wire logic              burstModeStrap,    // Order
  input wire logic [ADDR_W-1:0] memAddr,           // Beat
  input wire logic              memActive,         // Busy
  input wire logic              memWrite,          // Writing
  input wire logic [LANES-1:0]  memWrLane,         // Lanes
  input wire logic              dataDriveN         // Drive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic sel = !chipSel1N && chipSel2 && !chipSel3N;
  wire logic ld  = !clock_gate_n && !advance_or_load;
  wire logic stp = !clock_gate_n && advance_or_load;
  sequence sLdStep; ld && sel ##1 stp ##1 !clock_gate_n; endsequence
  a_write_load: assert property (ld && sel && !writeEnN |=> memActive && memWrite && dataDriveN
    && memWrLane == ~$past(byte_lane_write_n)) else $error("write load");
  a_read_load: assert property (ld && sel && writeEnN |=> memActive && !memWrite)
    else $error("read load");
  a_lane_step: assert property (stp && memWrite |=> memWrLane == ~$past(byte_lane_write_n))
    else $error("step lanes");
  a_addr_load: assert property (ld && sel ##1 !clock_gate_n |=> memAddr == $past(addrIn, 2))
    else $error("load address");
  a_burst_step: assert property (sLdStep |=> memAddr == {$past(addrIn[ADDR_W-1:2], 3),
    burstModeStrap ? $past(addrIn[1:0], 3) ^ 2'h1 : $past(addrIn[1:0], 3) + 2'h1})
    else $error("burst step");
  a_idle_step: assert property (!memActive && stp |=> !memActive)
    else $error("idle step");
  a_deselect: assert property (ld && !sel |=> !memActive && dataDriveN)
    else $error("deselect");
  a_gate_freeze: assert property (clock_gate_n |=> $stable(memAddr) && $stable(memActive)
    && $stable(memWrLane)) else $error("gate freeze");
endmodule : bsic_checker
bind bsic_top bsic_checker #(.ADDR_W(ADDR_W), .LANES(LANES)) u_chk (.*);

// [bench/bsic_ctl_model.sv]
// Controller model driving the front end's synchronous inputs except reset, burstModeStrap and outEnN.
// Assumes one drive call per cycle; outputs are reached by instance path.
module bsic_ctl_model #(parameter int ADDR_W = 19, parameter int LANES = 4) (
  input wire logic mclk // Clock
);
  logic clock_gate_n = 1'b0, advance_or_load = 1'b0, writeEnN = 1'b1, deselR = 1'b0;
  logic chipSel1N = 1'b1, chipSel2 = 1'b0, chipSel3N = 1'b1;
  logic [ADDR_W-1:0] addrIn = '0;
  logic [LANES-1:0]  byte_lane_write_n = '1;
  task automatic drive(input logic g, adv, we, input logic [2:0] s,
                       input logic [ADDR_W-1:0] a, input logic [LANES-1:0] l);
    @(negedge mclk);
    clock_gate_n = g;
    advance_or_load = adv && !deselR;
    writeEnN = we;
    {chipSel1N, chipSel2, chipSel3N} = s;
    addrIn = a;
    byte_lane_write_n = l;
    if (!g) deselR = !advance_or_load && s != 3'b010;
  endtask : drive
endmodule : bsic_ctl_model

// [bench/testbench.sv]
// Random loads, steps, deselects and gated edges in both burst orders.
// Assumes the design, checker and controller model compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 19;
  localparam int LN = 4;
  logic mclk = 1'b0, reset = 1'b1, burstModeStrap = 1'b0, outEnN = 1'b0, w;
  logic [AW-1:0] a, memAddr;
  logic [LN-1:0] l, e, memWrLane;
  logic [2:0] d;
  logic memActive, memWrite, dataDriveN;
  int n_mismatch = 0, check_count = 0;
  always #4 mclk = ~mclk;
  bsic_ctl_model #(.ADDR_W(AW), .LANES(LN)) ctl (.mclk);
  bsic_top #(.ADDR_W(AW), .LANES(LN)) dut (.mclk, .reset, .clock_gate_n(ctl.clock_gate_n),
    .addrIn(ctl.addrIn), .advance_or_load(ctl.advance_or_load), .writeEnN(ctl.writeEnN),
    .byte_lane_write_n(ctl.byte_lane_write_n), .chipSel1N(ctl.chipSel1N),
    .chipSel2(ctl.chipSel2), .chipSel3N(ctl.chipSel3N), .burstModeStrap, .outEnN,
    .memAddr, .memActive, .memWrite, .memWrLane, .dataDriveN, .parity_linesDriveN());
  task automatic chk(input logic [AW-1:0] seen, input logic [AW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [AW-1:0] stepped(input logic [AW-1:0] x, input logic il);
    return {x[AW-1:2], il ? x[1:0] ^ 2'h1 : x[1:0] + 2'h1};
  endfunction : stepped
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    a = AW'($urandom(32'h0C1D));
    for (int m = 0; m < 2; m++) begin
      burstModeStrap = m[0];
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      ctl.drive(1'b0, 1'b1, 1'b1, 3'b010, a, '1);
      for (int i = 0; i < 24; i++) begin
        a = AW'($urandom);
        l = LN'($urandom);
        w = 1'($urandom);
        d = 3'($urandom);
        if (d == 3'b010) d = 3'b111;
        if (i < 4) a[1:0] = i[1:0]; // Every start offset, wrap included
        ctl.drive(1'b0, 1'b0, w, 3'b010, a, l);
        ctl.drive(1'b0, 1'b1, !w, 3'b010, ~a, ~l);
        e = w ? '0 : ~l;
        chk(memActive, 1'b1);
        chk(memWrite, !w);
        chk(memWrLane, e);
        chk(dataDriveN, 1'b1);
        ctl.drive(1'b0, 1'b0, 1'b0, d, a, l);
        chk(dataDriveN, !w);
        e = w ? '0 : l;
        chk(memAddr, a);
        chk(memWrLane, e);
        ctl.drive(1'b1, 1'b0, 1'b0, 3'b010, ~a, l);
        chk(memAddr, stepped(a, m[0]));
        chk(memActive, 1'b0);
        chk(dataDriveN, 1'b1);
        ctl.drive(1'b0, 1'b0, 1'b1, 3'b101, a, l);
        chk(memActive, 1'b0);
      end
    end
    tally_and_finish();
  end
endmodule : testbench
